// ==== common/ptp_trig_consts.svh ====
// Purpose: offsets, field positions and limits of the trigger/timestamp control block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: included by bare name
`ifndef PTP_TRIG_CONSTS_SVH
`define PTP_TRIG_CONSTS_SVH
`define OFF_UNIT_INDEX 12'h520
`define OFF_CTRL_STATUS 12'h52c
`define OFF_TARGET_NS 12'h530
`define OFF_TARGET_S 12'h534
`define OFF_TRIG_CFG 12'h538
`define OFF_IRQ_STATUS 12'h540
`define OFF_IRQ_MASK 12'h544
`define OFF_SYS_NS 12'h548
`define OFF_SYS_S 12'h54c
`define BIT_CAP_SEL 8
`define BIT_OUT_SEL 8
`define BIT_PIN_IN 7
`define BIT_PIN_DIR 6
`define BIT_CAP_IRQ_EN 5
`define BIT_TRIG_ACTIVE 4
`define BIT_TRIG_EN 3
`define BIT_TRIG_SRST 2
`define BIT_CAP_EN 1
`define BIT_CAP_SRST 0
`define BIT_CFG_NOTIFY 24
`define BIT_CFG_NOW 25
`define NS_WIDTH 30
`define NS_PER_S 30'h3b9ac9ff
`define UNIT_SEL_RESERVED 2'h3
`define IRQ_DONE_LSB 0
`define IRQ_ERR_LSB 4
`define IRQ_CAP_LSB 8
`endif

// ==== common/ptp_trig_pkg.sv ====
// Purpose: types shared by the trigger/timestamp control block
// Assumes: nothing
// Notes: constants live in ptp_trig_consts.svh
package ptp_trig_pkg;
	typedef enum logic [1:0] {
		trig_idle = 2'b00,
		trig_armed = 2'b01,
		trig_done = 2'b10,
		trig_fault = 2'b11
	} trig_state_e;
	typedef logic [29:0] ns_t;
	typedef logic [31:0] sec_t;
endpackage

// ==== rtl/ptp_gpio_trigger_timestamp_ctrl.sv ====
// Purpose: control, target time and pin logic of a precision-time gpio pin
// Assumes: system time arrives as a synchronous input; apb slave, zero wait states
// Notes: capture storage and pulse shaping sit in neighbouring blocks
//
// Overview of operation
// - trigger bits follow the trigger index, capture bits follow the capture index.
// - output source 1 drives the pin from the combinational fire term through one flop, 0 through a second flop.
// - input monitor bit reads the live pin level, read only.
// - direction 1 makes the pin a capture input; 0, the default, a trigger output.
// - capture interrupts pass only while that unit's interrupt enable is set.
// - active reads 1 while the unit runs without error, else 0.
// - trigger soft reset returns the unit to inactive and clears notify and now; targets keep their values.
// - writing 1 to capture enable enables it and zeroes its event count.
// - capture soft reset returns the unit to inactive defaults.
// - per-unit 30-bit nanosecond target, reset zero, top two bits read zero.
// - per-unit 32-bit seconds target, reset zero.
// - target registers reach only the unit picked by the trigger index.
// - trigger index codes 0..2 pick units, code 3 is reserved.
// - with notify set and now clear, a target already past flags an error and interrupts.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "ptp_trig_consts.svh"
module ptp_gpio_trigger_timestamp_ctrl #(
	parameter int trig_units = 3,
	parameter int cap_units = 2,
	parameter int count_width = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [29:0] sys_ns,
	input wire logic [31:0] sys_s,
	input wire logic pin_in,
	input wire logic [cap_units-1:0] capture_event,
	output logic pin_out,
	output logic pin_oe,
	output logic [trig_units-1:0] trig_fire,
	output logic irq
);
	initial begin
		if (trig_units != 3 || cap_units < 1 || cap_units > 2 || count_width < 1)
			$error("unsupported unit counts");
	end

	logic [1:0] event_out_unit_select;
	logic capture_unit_select;
	logic output_source_select;
	logic pin_direction_select;
	logic [cap_units-1:0] capture_irq_enable;
	logic [cap_units-1:0] capture_unit_enable;
	logic [cap_units-1:0] capture_ready_flag;
	logic [cap_units-1:0] capture_count_overflow;
	logic [count_width-1:0] capture_event_count [cap_units];
	ptp_trig_pkg::trig_state_e trig_state [trig_units];
	ptp_trig_pkg::ns_t target_nanoseconds [trig_units];
	ptp_trig_pkg::sec_t target_seconds [trig_units];
	logic [trig_units-1:0] trig_notify;
	logic [trig_units-1:0] trig_now;
	logic [11:0] irq_status;
	logic [11:0] irq_mask;
	logic pin_flop;
	logic next_pin;

	logic wr_access;
	logic rd_access;
	logic sel_valid;
	logic [31:0] wdata;
	logic [trig_units-1:0] reached;
	logic [trig_units-1:0] fire_now;
	logic [trig_units-1:0] err_now;
	logic [trig_units-1:0] arm_wr;
	logic [trig_units-1:0] trig_srst;
	logic [cap_units-1:0] cap_wr;
	logic [cap_units-1:0] cap_srst;
	logic [cap_units-1:0] cap_ev;
	logic [31:0] next_rdata;

	assign wr_access = clk_en && psel && penable && pwrite;
	assign rd_access = clk_en && psel && penable && !pwrite;
	// byte strobes merge with zero so a partial write of a field stays simple
	assign wdata = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign sel_valid = event_out_unit_select != `UNIT_SEL_RESERVED;

	genvar gi;
	generate
		for (gi = 0; gi < trig_units; gi++) begin : g_trig
			logic hit;
			assign hit = sel_valid && event_out_unit_select == 2'(gi);
			// seconds decide first, nanoseconds only break a tie
			assign reached[gi] = (sys_s > target_seconds[gi]) ||
				(sys_s == target_seconds[gi] && sys_ns >= target_nanoseconds[gi]);
			assign arm_wr[gi] = wr_access && paddr == `OFF_CTRL_STATUS && hit;
			assign trig_srst[gi] = arm_wr[gi] && wdata[`BIT_TRIG_SRST];
			assign fire_now[gi] = trig_state[gi] == ptp_trig_pkg::trig_armed && reached[gi]
				&& !pin_direction_select;
			// with notify set, a target already in the past at arm time counts as an error unless forced now
			assign err_now[gi] = arm_wr[gi] && wdata[`BIT_TRIG_EN] && !wdata[`BIT_TRIG_SRST]
				&& trig_notify[gi] && !trig_now[gi] && reached[gi];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					trig_state[gi] <= ptp_trig_pkg::trig_idle;
				end else if (clk_en) begin
					if (trig_srst[gi]) begin
						trig_state[gi] <= ptp_trig_pkg::trig_idle;
					end else if (err_now[gi]) begin
						trig_state[gi] <= ptp_trig_pkg::trig_fault;
					end else if (arm_wr[gi]) begin
						if (wdata[`BIT_TRIG_EN])
							trig_state[gi] <= ptp_trig_pkg::trig_armed;
						else
							trig_state[gi] <= ptp_trig_pkg::trig_idle;
					end else if (fire_now[gi]) begin
						trig_state[gi] <= ptp_trig_pkg::trig_done;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					target_nanoseconds[gi] <= '0;
					target_seconds[gi] <= '0;
					trig_notify[gi] <= 1'b0;
					trig_now[gi] <= 1'b0;
				end else if (clk_en) begin
					if (trig_srst[gi]) begin
						trig_notify[gi] <= 1'b0;
						trig_now[gi] <= 1'b0;
					end else if (wr_access && hit && paddr == `OFF_TRIG_CFG) begin
						trig_notify[gi] <= wdata[`BIT_CFG_NOTIFY];
						trig_now[gi] <= wdata[`BIT_CFG_NOW];
					end
					if (wr_access && hit && paddr == `OFF_TARGET_NS)
						target_nanoseconds[gi] <= wdata[`NS_WIDTH-1:0];
					if (wr_access && hit && paddr == `OFF_TARGET_S)
						target_seconds[gi] <= wdata;
				end
			end
		end

		for (gi = 0; gi < cap_units; gi++) begin : g_cap
			assign cap_wr[gi] = wr_access && paddr == `OFF_CTRL_STATUS
				&& capture_unit_select == 1'(gi);
			assign cap_srst[gi] = cap_wr[gi] && wdata[`BIT_CAP_SRST];
			assign cap_ev[gi] = capture_event[gi] && capture_unit_enable[gi] && pin_direction_select;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					capture_unit_enable[gi] <= 1'b0;
					capture_irq_enable[gi] <= 1'b0;
					capture_ready_flag[gi] <= 1'b0;
					capture_count_overflow[gi] <= 1'b0;
					capture_event_count[gi] <= '0;
				end else if (clk_en) begin
					if (cap_srst[gi]) begin
						capture_unit_enable[gi] <= 1'b0;
						capture_irq_enable[gi] <= 1'b0;
						capture_ready_flag[gi] <= 1'b0;
						capture_count_overflow[gi] <= 1'b0;
						capture_event_count[gi] <= '0;
					end else if (cap_wr[gi]) begin
						capture_unit_enable[gi] <= wdata[`BIT_CAP_EN];
						capture_irq_enable[gi] <= wdata[`BIT_CAP_IRQ_EN];
						if (wdata[`BIT_CAP_EN]) begin
							capture_event_count[gi] <= '0;
						end else begin
							capture_ready_flag[gi] <= 1'b0;
							capture_count_overflow[gi] <= 1'b0;
						end
					end else if (cap_ev[gi]) begin
						capture_ready_flag[gi] <= 1'b1;
						if (&capture_event_count[gi])
							capture_count_overflow[gi] <= 1'b1;
						else
							capture_event_count[gi] <= capture_event_count[gi] + 1'b1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_out_unit_select <= 2'h0;
			capture_unit_select <= 1'b0;
			output_source_select <= 1'b0;
			pin_direction_select <= 1'b0;
		end else if (clk_en && wr_access) begin
			if (paddr == `OFF_UNIT_INDEX) begin
				event_out_unit_select <= wdata[1:0];
				capture_unit_select <= wdata[`BIT_CAP_SEL];
			end
			if (paddr == `OFF_CTRL_STATUS) begin
				output_source_select <= wdata[`BIT_OUT_SEL];
				pin_direction_select <= wdata[`BIT_PIN_DIR];
			end
		end
	end

	// status: done[2:0], error[6:4], capture[9:8]; a read clears, a new event wins
	logic [11:0] irq_set;
	always_comb begin
		irq_set = '0;
		for (int i = 0; i < trig_units; i++) begin
			irq_set[`IRQ_DONE_LSB + i] = fire_now[i] && trig_notify[i];
			irq_set[`IRQ_ERR_LSB + i] = err_now[i];
		end
		for (int i = 0; i < cap_units; i++)
			irq_set[`IRQ_CAP_LSB + i] = cap_ev[i] && capture_irq_enable[i];
	end

	// a read clears only the bits that it reported: prdata was latched at the setup edge,
	// so an event that lands between setup and access survives the clear
	logic [11:0] next_irq_status;
	always_comb begin
		next_irq_status = irq_status | irq_set;
		if (rd_access && paddr == `OFF_IRQ_STATUS)
			next_irq_status = (irq_status & ~prdata[11:0]) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (clk_en) begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (clk_en && wr_access && paddr == `OFF_IRQ_MASK) begin
			irq_mask <= wdata[11:0];
		end
	end

	// the level follows the status stored at the same edge, so it never lags a set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// the combinational path reaches the pin through one flop, in step with trig_fire, so it cannot glitch
	always_comb begin
		next_pin = |fire_now;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_flop <= 1'b0;
			pin_out <= 1'b0;
		end else if (clk_en) begin
			pin_flop <= next_pin;
			// outputs must come from flops, so the combinational source is one flop ahead
			pin_out <= output_source_select ? next_pin : pin_flop;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe <= 1'b0;
		end else if (clk_en) begin
			pin_oe <= !pin_direction_select;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_fire <= '0;
		end else if (clk_en) begin
			trig_fire <= fire_now;
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		case (paddr)
			`OFF_UNIT_INDEX: begin
				next_rdata[1:0] = event_out_unit_select;
				next_rdata[`BIT_CAP_SEL] = capture_unit_select;
			end
			`OFF_CTRL_STATUS: begin
				next_rdata[`BIT_OUT_SEL] = output_source_select;
				next_rdata[`BIT_PIN_IN] = pin_in;
				next_rdata[`BIT_PIN_DIR] = pin_direction_select;
				next_rdata[`BIT_CAP_IRQ_EN] = capture_irq_enable[capture_unit_select];
				next_rdata[`BIT_CAP_EN] = capture_unit_enable[capture_unit_select];
				if (sel_valid) begin
					next_rdata[`BIT_TRIG_ACTIVE] = trig_state[event_out_unit_select] ==
						ptp_trig_pkg::trig_armed;
					next_rdata[`BIT_TRIG_EN] = trig_state[event_out_unit_select] ==
						ptp_trig_pkg::trig_armed;
				end
			end
			`OFF_TARGET_NS:
				if (sel_valid)
					next_rdata[`NS_WIDTH-1:0] = target_nanoseconds[event_out_unit_select];
			`OFF_TARGET_S:
				if (sel_valid)
					next_rdata = target_seconds[event_out_unit_select];
			`OFF_TRIG_CFG:
				if (sel_valid) begin
					next_rdata[`BIT_CFG_NOTIFY] = trig_notify[event_out_unit_select];
					next_rdata[`BIT_CFG_NOW] = trig_now[event_out_unit_select];
				end
			`OFF_IRQ_STATUS: next_rdata[11:0] = irq_status;
			`OFF_IRQ_MASK: next_rdata[11:0] = irq_mask;
			`OFF_SYS_NS: next_rdata[`NS_WIDTH-1:0] = sys_ns;
			`OFF_SYS_S: next_rdata = sys_s;
			default: next_rdata = 32'h0;
		endcase
	end

	// no wait state: pready is high in the first access cycle, read data latched at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (clk_en) begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
				prdata <= next_rdata;
		end
	end
endmodule

// ==== verification/ptp_trig_properties.sv ====
// Purpose: bus and pin checks of the trigger/timestamp control block
// Assumes: clk_en held high
// Notes: bound to the top module below
`timescale 1ns/1ps
`include "ptp_trig_consts.svh"
module ptp_trig_properties #(
	parameter int trig_units = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pin_oe,
	input wire logic [trig_units-1:0] trig_fire
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	wire dir_wr = acc && pwrite && paddr == `OFF_CTRL_STATUS;
	logic dir_q;
	// pin_oe lags the register by a flop, so judge only once writes settle
	logic [1:0] quiet;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q <= 1'b0;
			quiet <= 2'h0;
		end else if (dir_wr) begin
			dir_q <= pwdata[`BIT_PIN_DIR];
			quiet <= 2'h0;
		end else if (quiet != 2'h3) begin
			quiet <= quiet + 2'h1;
		end
	end
	pready_wait_a: assert property (psel && !penable |=> pready)
		else $error("pready not in the cycle after setup");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	no_error_a: assert property (!pslverr)
		else $error("pslverr raised");
	rdata_hold_a: assert property (pready |=> $stable(prdata))
		else $error("read data changed after answer");
	ns_upper_a: assert property (acc && !pwrite && paddr == `OFF_TARGET_NS |-> prdata[31:30] == 2'h0)
		else $error("nanosecond upper bits not zero");
	ctrl_reserved_a: assert property (acc && !pwrite && paddr == `OFF_CTRL_STATUS |-> prdata[31:9] == '0)
		else $error("control reserved bits not zero");
	dir_pin_a: assert property (quiet == 2'h3 |-> pin_oe == !dir_q)
		else $error("pin enable disagrees with direction");
	fire_pulse_a: assert property (|trig_fire |=> (trig_fire & $past(trig_fire)) == '0)
		else $error("fire pulse longer than one cycle");
endmodule
bind ptp_gpio_trigger_timestamp_ctrl ptp_trig_properties #(.trig_units(trig_units)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe), .trig_fire(trig_fire));

// ==== verification/tb_ptp_gpio_trigger_timestamp_ctrl.sv ====
// Purpose: self-checking bench of the trigger/timestamp control block
// Assumes: apb answers with no wait state; the master still waits for pready
// Notes: reads and fire pulses are judged against queued notes
`timescale 1ns/1ps
`include "ptp_trig_consts.svh"
module tb_ptp_gpio_trigger_timestamp_ctrl;
	typedef struct {string n; logic [31:0] e; logic [31:0] m;} note_s;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_in = 0;
	logic pready, pslverr, pin_oe, irq, pin_out;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rnd = 32'h19, sys_s = '0;
	logic [29:0] sys_ns = '0;
	logic [1:0] cap_ev = '0;
	logic [2:0] trig_fire;
	logic [31:0] tn[4], ts[4];
	note_s rq[$], fq[$], nt;
	int n_mismatch = 0, n_compared = 0;
	always #5 pclk = ~pclk;
	ptp_gpio_trigger_timestamp_ctrl uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sys_ns(sys_ns), .sys_s(sys_s), .pin_in(pin_in),
		.capture_event(cap_ev), .pin_out(pin_out), .pin_oe(pin_oe), .trig_fire(trig_fire), .irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		n_mismatch += fq.size() + rq.size();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		rq.push_back('{n, e & m, m});
		apb(1'b0, a, 32'h0);
	endtask
	// target fixed at 5 s 999 ns; time t0 must not fire, t1 must
	// sel picks the pin source: 1 shows the pin with the fire pulse, 0 one cycle later
	task automatic fire_case(input int u, input logic sel, input logic [31:0] s0, s1, input logic [29:0] n0, n1);
		wr(`OFF_UNIT_INDEX, 32'(u));
		wr(`OFF_TARGET_NS, 32'd999);
		wr(`OFF_TARGET_S, 32'd5);
		sys_s <= s0;
		sys_ns <= n0;
		wr(`OFF_CTRL_STATUS, {23'h0, sel, 8'h8});
		rd("armed", `OFF_CTRL_STATUS, 32'h18, 32'h18);
		fq.push_back('{"fire", {28'h0, sel, 3'(1 << u)}, 32'hf});
		sys_s <= s1;
		sys_ns <= n1;
		rd("sys_ns", `OFF_SYS_NS, {2'h0, n1});
		rd("fired", `OFF_CTRL_STATUS, 32'h0, 32'h18);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rq.size() > 0) begin
			nt = rq.pop_front();
			chk(nt.n, prdata & nt.m, nt.e);
		end
		if (trig_fire !== 3'h0) begin
			if (fq.size() > 0)
				nt = fq.pop_front();
			else
				nt = '{"stray_fire", 32'h0, 32'h7};
			chk(nt.n, {28'h0, pin_out, trig_fire}, nt.e);
		end
	end
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("ctrl_rst", `OFF_CTRL_STATUS, 32'h0, 32'hffffff7f);
		for (int u = 0; u < 4; u++) begin
			wr(`OFF_UNIT_INDEX, 32'(u));
			rd("ns_rst", `OFF_TARGET_NS, 32'h0);
			rd("s_rst", `OFF_TARGET_S, 32'h0);
			rnd = lfsr(rnd);
			tn[u] = (u == 3) ? 32'h0 : rnd & 32'h3fffffff;
			wr(`OFF_TARGET_NS, rnd);
			rnd = lfsr(rnd);
			ts[u] = (u == 3) ? 32'h0 : rnd;
			wr(`OFF_TARGET_S, rnd);
		end
		for (int u = 0; u < 4; u++) begin
			wr(`OFF_UNIT_INDEX, 32'(u));
			rd("ns", `OFF_TARGET_NS, tn[u]);
			rd("s", `OFF_TARGET_S, ts[u]);
		end
		for (int v = 1; v >= 0; v--) begin
			pin_in <= v[0];
			wr(`OFF_CTRL_STATUS, {23'h0, v[0], 1'b0, v[0], 6'h0});
			rd("ctrl_pin", `OFF_CTRL_STATUS, {23'h0, {3{v[0]}}, 6'h0}, 32'h1c0);
		end
		fire_case(0, 1'b0, 32'd5, 32'd5, 30'd998, 30'd999);
		fire_case(1, 1'b1, 32'd4, 32'd6, 30'd1000, 30'd0);
		wr(`OFF_UNIT_INDEX, 32'h2);
		wr(`OFF_TRIG_CFG, 32'h1000000);
		wr(`OFF_TARGET_S, 32'h1);
		sys_s <= 32'd5;
		wr(`OFF_IRQ_MASK, 32'hffffffff);
		rd("mask", `OFF_IRQ_MASK, 32'h377, 32'h377);
		wr(`OFF_CTRL_STATUS, 32'h8);
		rd("late_active", `OFF_CTRL_STATUS, 32'h0, 32'h10);
		chk("irq_err", {31'h0, irq}, 32'h1);
		rd("err_irq", `OFF_IRQ_STATUS, 32'h40, 32'h40);
		rd("err_clr", `OFF_IRQ_STATUS, 32'h0, 32'h40);
		chk("irq_clr", {31'h0, irq}, 32'h0);
		wr(`OFF_CTRL_STATUS, 32'h0);
		wr(`OFF_UNIT_INDEX, 32'h0);
		sys_s <= 32'd0;
		wr(`OFF_CTRL_STATUS, 32'h8);
		rd("armed0", `OFF_CTRL_STATUS, 32'h18, 32'h18);
		wr(`OFF_CTRL_STATUS, 32'h4);
		rd("trig_srst", `OFF_CTRL_STATUS, 32'h0, 32'h18);
		wr(`OFF_UNIT_INDEX, 32'h103);
		wr(`OFF_CTRL_STATUS, 32'h62);
		rd("cap1", `OFF_CTRL_STATUS, 32'h22, 32'h3a);
		cap_ev <= 2'h3;
		@(posedge pclk);
		cap_ev <= 2'h0;
		rd("cap_irq", `OFF_IRQ_STATUS, 32'h200, 32'h300);
		wr(`OFF_UNIT_INDEX, 32'h3);
		rd("cap0", `OFF_CTRL_STATUS, 32'h0, 32'h22);
		wr(`OFF_UNIT_INDEX, 32'h103);
		wr(`OFF_CTRL_STATUS, 32'h1);
		rd("cap_srst", `OFF_CTRL_STATUS, 32'h0, 32'h22);
		end_sim();
	end
endmodule
